/* File: pmbs_consts.svh */
`ifndef PMBS_CONSTS_SVH
`define PMBS_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register map (byte addresses on APB)
// ----------------------------------------------------------------------------
`define PMBS_OFS_CTRL 12'h000
`define PMBS_OFS_ADDR 12'h004
`define PMBS_OFS_STATUS 12'h008
`define PMBS_OFS_CMD 12'h00C
`define PMBS_OFS_WDATA 12'h010
`define PMBS_OFS_RDATA 12'h014
`define PMBS_OFS_FAULT 12'h018
`define PMBS_OFS_VOUT 12'h01C
`define PMBS_OFS_TEMP 12'h020
`define PMBS_OFS_CONV 12'h024
// ----------------------------------------------------------------------------
// Field positions, reset values, command and mode codes, byte limits
// ----------------------------------------------------------------------------
`define PMBS_CTRL_EN_BIT 0
`define PMBS_ADDR_RST 7'h32
`define PMBS_ARA_ADDR 7'h0C
`define PMBS_CMD_CLEAR_FAULTS 8'h03
`define PMBS_CMD_VOUT_MODE 8'h20
`define PMBS_MODE_LINEAR16 8'h12
`define PMBS_MODE_SLINEAR16 8'h11
`define PMBS_EXP_LINEAR16 5'h12
`define PMBS_EXP_SLINEAR16 5'h11
`define PMBS_MAX_BYTES 3'h7
`define PMBS_RD_BYTES 3'h4
`endif

/* File: pmbs_pkg.sv */
package pmbs_pkg;
   // Frame engine states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_WRX = 3'b010,
      ST_TX = 3'b011,
      ST_ACK = 3'b100,
      ST_RACK = 3'b101,
      ST_SKIP = 3'b110
   } pmbs_state_t;

   // APB request bundle
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pmbs_apb_req_t;

   // APB answer bundle
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pmbs_apb_rsp_t;

   // Open-drain pin bundle; oe_n low means pulled low
   typedef struct packed {
      logic scl_oe_n;
      logic sda_oe_n;
      logic alert_oe_n;
   } pmbs_pins_t;

   // Whole state of the block
   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic [1:0] flt_s;
      logic scl_d;
      logic sda_d;
      pmbs_state_t st;
      logic [2:0] bitc;
      logic byte_rdy;
      logic [7:0] sh;
      logic rw;
      logic [2:0] nbyte;
      logic [7:0] cmd;
      logic [55:0] wbuf;
      logic [31:0] rdat;
      logic en;
      logic [6:0] addr;
      logic ara;
      logic [7:0] fault;
      logic [7:0] vmode;
      logic [31:0] conv;
      logic [31:0] lcmd;
      logic [55:0] lw;
      logic [2:0] lcnt;
      logic done;
      pmbs_pins_t pins;
      pmbs_apb_rsp_t rsp;
   } pmbs_state_all_t;
endpackage

/* File: pmbs_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pmbs_consts.svh"

// Contract
// - Acknowledge is data low in ninth slot
// - Bit after address: 1 read, 0 write
// - Repeated start restarts address, keeps command
// - Command byte carries register address selection; reads return rdat whatever the command
// - Encode/decode per command format
// - LINEAR16 unsigned mantissa times 2^-14
// - SLINEAR16 signed mantissa times 2^-15
// - Mode byte zero mode, exponent -14/-15
// - LINEAR11 5-bit exponent, 11-bit mantissa
// - Zero-data write executes on stop
// - Acknowledge the first six received data bytes
// - 48-bit register write, bytes acknowledged
// - Reads return up to 32 bits
// - Open-drain lines, released by tri-state
// - Alert output and alert response address
// - Alert held while fault persists
// - CLEAR_FAULTS clears faults, releases alert
// - Interface ignores bus until enabled
module pmbs_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire pmbs_pkg::pmbs_apb_req_t apb_req,
   output var pmbs_pkg::pmbs_apb_rsp_t apb_rsp,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [7:0] fault_in,
   output var pmbs_pkg::pmbs_pins_t pins,
   output logic cmd_strobe,
   output logic [7:0] cmd_code,
   output logic [55:0] cmd_data,
   output logic [2:0] cmd_bytes
);

   // ---------------------------------------------------------------------
   // Decoders
   // ---------------------------------------------------------------------
   // Sign-extended LINEAR11 mantissa
   function automatic logic [15:0] l11_mant(input logic [15:0] v);
      l11_mant = {{5{v[10]}}, v[10:0]};
   endfunction

   // Sign-extended LINEAR11 exponent
   function automatic logic [15:0] l11_exp(input logic [15:0] v);
      l11_exp = {{11{v[15]}}, v[15:11]};
   endfunction

   // Whole block state and its next value
   pmbs_pkg::pmbs_state_all_t s_reg, s_next;
   // Bus line events seen this cycle
   logic scl_rise, scl_fall, start_c, stop_c;
   logic [11:0] a; // Register offset of the APB request
   logic [31:0] rd; // Read mux output
   // Register bus qualifiers
   logic wr_hit, rd_hit;

   // ---------------------------------------------------------------------
   // Bus line events, only from second synchroniser stage
   // ---------------------------------------------------------------------
   always_comb begin
      scl_rise = s_reg.scl_s[1] & ~s_reg.scl_d;
      scl_fall = ~s_reg.scl_s[1] & s_reg.scl_d;
      // Data moving while clock high frames the transfer
      start_c = s_reg.scl_s[1] & s_reg.scl_d & s_reg.sda_d & ~s_reg.sda_s[1];
      stop_c = s_reg.scl_s[1] & s_reg.scl_d & ~s_reg.sda_d & s_reg.sda_s[1];
      a = apb_req.paddr;
      // A write lands only at the edge where the master sees pready high
      wr_hit = apb_req.psel & apb_req.penable & apb_req.pwrite & s_reg.rsp.pready;
      // Read word is captured the edge before pready shows, so it stands with it
      rd_hit = apb_req.psel & apb_req.penable & ~apb_req.pwrite & ~s_reg.rsp.pready;
   end

   // ---------------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------------
   always_comb begin
      case (a)
         `PMBS_OFS_CTRL: rd = {31'h0, s_reg.en};
         `PMBS_OFS_ADDR: rd = {25'h0, s_reg.addr};
         `PMBS_OFS_STATUS: rd = {24'h0, s_reg.lcnt, 1'b0, s_reg.st == pmbs_pkg::ST_IDLE,
                                 s_reg.st};
         `PMBS_OFS_CMD: rd = {24'h0, s_reg.lcmd[7:0]};
         `PMBS_OFS_WDATA: rd = s_reg.lw[31:0];
         `PMBS_OFS_RDATA: rd = s_reg.rdat;
         `PMBS_OFS_FAULT: rd = {24'h0, s_reg.fault};
         `PMBS_OFS_VOUT: rd = {24'h0, s_reg.vmode};
         // LINEAR11 split: exponent high half, mantissa low half
         `PMBS_OFS_TEMP: rd = {l11_exp(s_reg.conv[15:0]), l11_mant(s_reg.conv[15:0])};
         `PMBS_OFS_CONV: rd = s_reg.conv;
         // Unmapped offsets read as zero
         default: rd = 32'h0;
      endcase
   end

   // ---------------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      s_next.rsp.pready = 1'b0;
      s_next.rsp.pslverr = 1'b0;
      // Two-flop synchronisers for outside pins
      s_next.scl_s = {s_reg.scl_s[0], scl_in};
      s_next.sda_s = {s_reg.sda_s[0], sda_in};
      s_next.flt_s = {s_reg.flt_s[0], |fault_in};
      s_next.scl_d = s_reg.scl_s[1];
      s_next.sda_d = s_reg.sda_s[1];
      // Latch faults while condition holds; set wins over clear
      s_next.fault = s_reg.fault | fault_in;
      // APB: one wait state; pready stands for a single cycle so that a
      // held request is never answered twice
      if (apb_req.psel & apb_req.penable & ~s_reg.rsp.pready) begin
         s_next.rsp.pready = 1'b1;
      end
      if (rd_hit) begin
         s_next.rsp.prdata = rd;
      end
      if (wr_hit) begin
         case (a)
            `PMBS_OFS_CTRL: s_next.en = apb_req.pwdata[`PMBS_CTRL_EN_BIT];
            `PMBS_OFS_ADDR: s_next.addr = apb_req.pwdata[6:0];
            `PMBS_OFS_RDATA: s_next.rdat = apb_req.pwdata;
            `PMBS_OFS_FAULT: s_next.fault = (s_reg.fault & ~apb_req.pwdata[7:0]) | fault_in;
            `PMBS_OFS_CONV: s_next.conv = apb_req.pwdata;
            default: s_next.rsp.pslverr = 1'b0;
         endcase
      end
      // Protocol engine
      // Lines are sampled after clock rise and driven after clock fall
      if (!s_reg.en) begin
         // Disabled: release lines, ignore traffic
         s_next.st = pmbs_pkg::ST_IDLE;
         s_next.pins.sda_oe_n = 1'b1;
      end else if (stop_c) begin
         // Write completes on stop
         // A frame cut before the command byte runs nothing
         if (s_reg.st != pmbs_pkg::ST_IDLE && !s_reg.rw && s_reg.nbyte != 3'h0) begin
            s_next.done = 1'b1;
            s_next.lcmd = {24'h0, s_reg.cmd};
            s_next.lw = s_reg.wbuf;
            s_next.lcnt = s_reg.nbyte - 3'h1;
            if (s_reg.cmd == `PMBS_CMD_CLEAR_FAULTS) begin
               s_next.fault = fault_in;
            end
            if (s_reg.cmd == `PMBS_CMD_VOUT_MODE && s_reg.nbyte == 3'h2) begin
               // Only linear mode with a legal exponent is accepted
               if (s_reg.wbuf[7:5] == 3'h0 && (s_reg.wbuf[4:0] == `PMBS_EXP_LINEAR16 ||
                   s_reg.wbuf[4:0] == `PMBS_EXP_SLINEAR16)) begin
                  s_next.vmode = s_reg.wbuf[7:0];
               end
            end
         end
         s_next.st = pmbs_pkg::ST_IDLE;
         s_next.pins.sda_oe_n = 1'b1;
      end else if (start_c) begin
         // Start or repeated start: new address phase, command kept
         s_next.st = pmbs_pkg::ST_ADDR;
         s_next.bitc = 3'h0;
         // The clock fall that ends a start carries no data; only a byte
         // that has seen eight rises may be decoded
         s_next.byte_rdy = 1'b0;
         s_next.pins.sda_oe_n = 1'b1;
      end else begin
         case (s_reg.st)
            pmbs_pkg::ST_IDLE: s_next.pins.sda_oe_n = 1'b1;
            pmbs_pkg::ST_ADDR, pmbs_pkg::ST_WRX: begin
               if (scl_rise) begin
                  // MSB first within byte
                  s_next.sh = {s_reg.sh[6:0], s_reg.sda_s[1]};
                  s_next.bitc = s_reg.bitc + 3'h1;
                  // Eighth rise completes the byte
                  s_next.byte_rdy = (s_reg.bitc == 3'h7);
               end
               if (scl_fall && s_reg.byte_rdy && s_reg.st == pmbs_pkg::ST_ADDR) begin
                  s_next.byte_rdy = 1'b0;
                  s_next.ara = s_reg.sh[7:1] == `PMBS_ARA_ADDR;
                  // Alert address answered while a fault is latched
                  if (s_reg.sh[7:1] == s_reg.addr ||
                      (s_reg.sh[7:1] == `PMBS_ARA_ADDR && (s_reg.flt_s[1] | (|s_reg.fault)))) begin
                     s_next.rw = s_reg.sh[0];
                     s_next.st = pmbs_pkg::ST_ACK;
                     s_next.pins.sda_oe_n = 1'b0;
                     if (!s_reg.sh[0]) begin
                        s_next.nbyte = 3'h0;
                        s_next.wbuf = 56'h0;
                     end
                     // Alert response returns own address; else read data
                     s_next.sh = (s_reg.sh[7:1] == `PMBS_ARA_ADDR) ?
                                 {s_reg.addr, 1'b0} : s_reg.rdat[7:0];
                  end else begin
                     s_next.st = pmbs_pkg::ST_SKIP;
                  end
               end else if (scl_fall && s_reg.byte_rdy &&
                            s_reg.st == pmbs_pkg::ST_WRX) begin
                  s_next.byte_rdy = 1'b0;
                  // Each received byte acknowledged, up to 48 data bits; an eighth
                  // byte is refused so the buffer can never overflow
                  s_next.st = pmbs_pkg::ST_ACK;
                  s_next.pins.sda_oe_n = (s_reg.nbyte == `PMBS_MAX_BYTES);
                  if (s_reg.nbyte == 3'h0) begin
                     s_next.cmd = s_reg.sh;
                  end else if (s_reg.nbyte != `PMBS_MAX_BYTES) begin
                     // Data byte lands low byte first; the command byte selects target reg
                     s_next.wbuf = s_reg.wbuf | (56'(s_reg.sh) << (8 * (s_reg.nbyte - 3'h1)));
                  end
                  if (s_reg.nbyte != `PMBS_MAX_BYTES) begin
                     s_next.nbyte = s_reg.nbyte + 3'h1;
                  end
               end
            end
            pmbs_pkg::ST_ACK: begin
               // After the ninth clock: release for a write, drive the first data bit for a read
               if (scl_fall) begin
                  s_next.bitc = 3'h0;
                  if (s_reg.rw) begin
                     s_next.st = pmbs_pkg::ST_TX;
                     s_next.nbyte = 3'h0;
                     s_next.pins.sda_oe_n = s_reg.sh[7];
                  end else begin
                     s_next.st = pmbs_pkg::ST_WRX;
                     s_next.pins.sda_oe_n = 1'b1;
                  end
               end
            end
            pmbs_pkg::ST_TX: begin
               // Bits change on clock fall so the line is steady while it is high
               if (scl_fall) begin
                  s_next.bitc = s_reg.bitc + 3'h1;
                  if (s_reg.bitc == 3'h7) begin
                     // Release for host acknowledge
                     s_next.st = pmbs_pkg::ST_RACK;
                     s_next.pins.sda_oe_n = 1'b1;
                     s_next.nbyte = s_reg.nbyte + 3'h1;
                  end else begin
                     s_next.sh = {s_reg.sh[6:0], 1'b1};
                     s_next.pins.sda_oe_n = s_reg.sh[6];
                  end
               end
            end
            pmbs_pkg::ST_RACK: begin
               if (scl_rise) begin
                  // Host nack, an alert response byte or 32 bits sent ends the read
                  if (s_reg.sda_s[1] || s_reg.ara || s_reg.nbyte == `PMBS_RD_BYTES) begin
                     s_next.st = pmbs_pkg::ST_SKIP;
                  end else begin
                     // Next byte fetched on the acknowledge rise, ready for the fall
                     s_next.sh = s_reg.rdat[8 * s_reg.nbyte +: 8];
                  end
               end
               if (scl_fall) begin
                  s_next.st = pmbs_pkg::ST_TX;
                  s_next.bitc = 3'h0;
                  s_next.pins.sda_oe_n = s_reg.sh[7];
               end
            end
            pmbs_pkg::ST_SKIP: s_next.pins.sda_oe_n = 1'b1;
            default: s_next.st = pmbs_pkg::ST_IDLE;
         endcase
      end
      // Alert tracks fault state: held until cleared
      s_next.pins.alert_oe_n = ~(|s_next.fault & s_reg.en);
      // Clock line is never stretched: the host must allow about three
      // cycles of synchroniser delay in each clock phase
      s_next.pins.scl_oe_n = 1'b1;
   end

   // ---------------------------------------------------------------------
   // State register; clock enable freezes everything
   // ---------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         // Line history starts at the idle high level: no false edge after reset
         s_reg.scl_s <= 2'h3;
         s_reg.sda_s <= 2'h3;
         s_reg.scl_d <= 1'b1;
         s_reg.sda_d <= 1'b1;
         s_reg.addr <= `PMBS_ADDR_RST;
         s_reg.vmode <= `PMBS_MODE_LINEAR16;
         s_reg.pins <= 3'h7;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   // ---------------------------------------------------------------------
   // Outputs straight from flops
   // ---------------------------------------------------------------------
   // SLINEAR16 data is passed raw; mode byte tells host the scaling
   assign apb_rsp = s_reg.rsp;
   assign pins = s_reg.pins;
   assign cmd_strobe = s_reg.done;
   assign cmd_code = s_reg.lcmd[7:0];
   assign cmd_data = s_reg.lw;
   assign cmd_bytes = s_reg.lcnt;

endmodule
`default_nettype wire

/* File: pmbs_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module pmbs_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire pmbs_pkg::pmbs_apb_req_t apb_req,
   input wire pmbs_pkg::pmbs_apb_rsp_t apb_rsp,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [7:0] fault_in,
   input wire pmbs_pkg::pmbs_pins_t pins,
   input wire logic cmd_strobe,
   input wire logic [2:0] cmd_bytes
);
   logic en_q; // Mirror of the enable bit, seen from the bus side
   // --------
   // Enable mirror
   // --------
   // Follows the write that completes at the pready edge, as the slave does
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
      end else if (clk_en && apb_req.psel && apb_req.penable && apb_rsp.pready
                   && apb_req.pwrite && apb_req.paddr == 12'h000) begin
         en_q <= apb_req.pwdata[0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Setup cycle, then one wait state, then a single-cycle answer
   sequence apb_setup;
      clk_en && apb_req.psel && !apb_req.penable;
   endsequence
   sequence apb_answer;
      !apb_rsp.pready ##1 apb_rsp.pready ##1 !apb_rsp.pready;
   endsequence
   chk_apb_answer: assert property (apb_setup |=> apb_answer)
      else $error("pready not one cycle after the wait state");
   chk_scl_released: assert property (pins.scl_oe_n)
      else $error("clock line pulled by the slave");
   chk_sda_scl_low: assert property ($changed(pins.sda_oe_n) |-> !scl_in)
      else $error("data line moved while clock high");
   chk_strobe_pulse: assert property (cmd_strobe |=> !cmd_strobe)
      else $error("command strobe longer than one cycle");
   chk_strobe_stop: assert property (cmd_strobe |-> scl_in && sda_in)
      else $error("command strobe outside a stop");
   chk_bytes_max: assert property (cmd_strobe |-> cmd_bytes <= 3'h6)
      else $error("too many data bytes reported");
   chk_alert_raise: assert property (en_q && fault_in != 8'h00 |-> ##[1:6] !pins.alert_oe_n)
      else $error("alert not raised for a fault");
   chk_alert_held: assert property (en_q && fault_in != 8'h00 && !pins.alert_oe_n |=> !pins.alert_oe_n)
      else $error("alert dropped while fault present");
   chk_quiet_off: assert property (!en_q && !$past(en_q) |-> pins.sda_oe_n && pins.alert_oe_n)
      else $error("bus driven while disabled");
endmodule
bind pmbs_core pmbs_properties u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .scl_in(scl_in), .sda_in(sda_in),
   .fault_in(fault_in), .pins(pins), .cmd_strobe(cmd_strobe), .cmd_bytes(cmd_bytes));
`default_nettype wire

/* File: pmbs_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// --------
// Bus host: open-drain, high means released
// --------
module pmbs_host_model (
   input wire logic sda,
   output logic scl_drv,
   output logic sda_drv
);
   // Idle: both released, clock stands still between frames
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   // Start or repeated start; no stop is needed before a restart
   task automatic start();
      #8 sda_drv = 1'b1;
      #8 scl_drv = 1'b1;
      #16 sda_drv = 1'b0;
      #16 scl_drv = 1'b0;
   endtask
   // Stop: data rises while clock is high
   task automatic stop();
      #8 sda_drv = 1'b0;
      #8 scl_drv = 1'b1;
      #16 sda_drv = 1'b1;
      #16;
   endtask
   // Eight bits and the ninth slot; o[0] is our ack, r[0] what the line held
   task automatic xbyte(input logic [8:0] o, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin // MSB first
         #8 sda_drv = o[i]; // Ack low, nack or release high
         #8 scl_drv = 1'b1;
         #8 r[i] = sda;
         #8 scl_drv = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic pclk, cmd_strobe, h_scl, h_sda, scl, sda;
   logic presetn = 1'b0, clk_en = 1'b1; // Held in reset at time zero
   logic [7:0] fault_in = 8'h00, cmd_code, s_code;
   logic [55:0] cmd_data, s_data, rd, s_cnt = '0;
   logic [2:0] cmd_bytes, s_bytes;
   logic [15:0] rnd = 16'hECBA; // Fixed seed
   int fail_count = 0, comparisons = 0;
   pmbs_pkg::pmbs_apb_req_t req = '0;
   pmbs_pkg::pmbs_apb_rsp_t rsp;
   pmbs_pkg::pmbs_pins_t pins;
   // Wired-AND with pull-ups on both lines
   assign scl = h_scl & pins.scl_oe_n;
   assign sda = h_sda & pins.sda_oe_n;
   pmbs_core DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(req),
      .apb_rsp(rsp), .scl_in(scl), .sda_in(sda), .fault_in(fault_in), .pins(pins),
      .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_bytes(cmd_bytes));
   pmbs_host_model hm (.sda(sda), .scl_drv(h_scl), .sda_drv(h_sda));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Strobe is one cycle wide, so latch it when seen
   always @(posedge pclk) begin
      if (cmd_strobe === 1'b1) begin
         s_cnt++;
         s_code = cmd_code;
         s_data = cmd_data;
         s_bytes = cmd_bytes;
      end
   end
   // --------
   // Helpers
   // --------
   function automatic logic [15:0] nxt();
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      return rnd;
   endfunction
   // Signed exponent and mantissa, each widened to 16 bits
   function automatic logic [31:0] l11(input logic [15:0] v);
      return {{11{v[15]}}, v[15:11], {5{v[10]}}, v[10:0]};
   endfunction
   task automatic chk(input string n, input logic [55:0] e, input logic [55:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic close_out();
      if (fail_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Request held until pready is sampled high; no latency assumed
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do @(posedge pclk); while (rsp.pready !== 1'b1);
      rd = {24'h000000, rsp.prdata};
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   // Write frame; a collects every ack slot
   task automatic wframe(input logic [7:0] c, input int n, input logic [55:0] d,
                         output logic [9:0] a);
      logic [8:0] r;
      a = '0;
      @(negedge pclk);
      hm.start();
      hm.xbyte({7'h32, 2'b01}, r); // Write direction bit 0
      a[0] = r[0];
      hm.xbyte({c, 1'b1}, r); // Command code after the address
      a[1] = r[0];
      for (int i = 0; i < n; i++) begin
         hm.xbyte({d[8*i+:8], 1'b1}, r); // Low byte first
         a[i+2] = r[0];
      end
      hm.stop(); // Stop only after the last ack
      repeat (8) @(posedge pclk);
   endtask
   // Command, repeated start, four bytes back
   task automatic rframe(input logic [7:0] c, output logic [55:0] v);
      logic [8:0] r;
      v = '0;
      @(negedge pclk);
      hm.start();
      hm.xbyte({7'h32, 2'b01}, r);
      hm.xbyte({c, 1'b1}, r);
      hm.start(); // Restart with no stop
      hm.xbyte({7'h32, 2'b11}, r); // Read direction bit 1
      for (int i = 0; i < 4; i++) begin
         hm.xbyte({8'hFF, i == 3}, r); // Ack between bytes, nack the last
         v[8*i+:8] = r[8:1];
      end
      hm.stop();
   endtask
   // Watchdog: far beyond the dozen frames of the run
   initial begin
      #200000;
      fail_count++;
      close_out();
   end
   // --------
   // Main sequence
   // --------
   initial begin
      logic [9:0] a;
      logic [8:0] r;
      logic [55:0] d, e;
      int n;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk("addr reset", 56'h32, rd);
      apb(1'b0, 12'h3FC, 32'h0);
      chk("unmapped", 56'h0, rd);
      wframe(8'h03, 0, '0, a);
      chk("off ack", 56'h1, a[0]);
      chk("off strobe", 56'h0, s_cnt);
      apb(1'b1, 12'h000, 32'h1);
      wframe(8'h03, 0, '0, a);
      chk("zero acks", 56'h0, a);
      chk("zero code", 56'h010300, {s_cnt[7:0], s_code, 5'h0, s_bytes});
      // Random commands with 1, 2, 6 and 7 data bytes; the seventh is refused
      for (int k = 0; k < 4; k++) begin
         n = (k == 3) ? 7 : (k == 2) ? 6 : k + 1;
         d = 56'({nxt(), nxt(), nxt(), nxt()});
         e = (56'h1 << (8 * ((n > 6) ? 6 : n))) - 56'h1;
         wframe({2'b01, 6'(rnd)}, n, d, a);
         chk("data acks", (n == 7) ? 56'h100 : 56'h0, a);
         chk("cmd code", {2'b01, 6'(rnd)}, s_code);
         chk("byte count", (n > 6) ? 56'h6 : 56'(n), s_bytes);
         chk("cmd data", d & e, s_data);
      end
      d = 56'({nxt(), nxt()});
      apb(1'b1, 12'h014, d[31:0]);
      rframe(8'h8B, e);
      chk("read word", d, e);
      // Mode byte: both linear codes taken, a non-linear mode refused
      for (int k = 0; k < 3; k++) begin
         wframe(8'h20, 1, (k == 0) ? 56'h12 : (k == 1) ? 56'h11 : 56'h32, a);
         apb(1'b0, 12'h01C, 32'h0);
         chk("vout mode", (k == 0) ? 56'h12 : 56'h11, rd);
      end
      for (int k = 0; k < 4; k++) begin
         d = (k == 0) ? 56'hEA81 : (k == 1) ? 56'h07EC : (k == 2) ? 56'h0050 : 56'(nxt());
         apb(1'b1, 12'h024, d[31:0]);
         apb(1'b0, 12'h020, 32'h0);
         chk("temp decode", l11(d[15:0]), rd);
      end
      @(posedge pclk);
      fault_in <= 8'h04;
      repeat (8) @(posedge pclk);
      fault_in <= 8'h00;
      chk("alert on", 56'h0, pins.alert_oe_n);
      repeat (8) @(posedge pclk);
      chk("alert kept", 56'h0, pins.alert_oe_n);
      @(negedge pclk);
      hm.start();
      hm.xbyte({7'h0C, 2'b11}, r);
      hm.xbyte(9'h1FF, r);
      hm.stop();
      chk("alert reply", 56'h64, r[8:1]);
      wframe(8'h03, 0, '0, a);
      chk("alert cleared", 56'h1, pins.alert_oe_n);
      close_out();
   end
endmodule
`default_nettype wire
